/* pkg/adc_regs_pkg.sv */
// Constants, field positions and carrier types of the board register bank
package adc_regs_pkg;
   localparam int unsigned ADDR_W     = 7;
   localparam int unsigned FIFO_DEPTH = 16;
   localparam int unsigned PTR_W      = 4;
   localparam int unsigned CNT_W      = 5;
   localparam logic [4:0]  FIFO_FULL_CNT = 5'h10;

   // Byte offsets inside the 32-longword window
   localparam logic [6:0] OFS_BOARD_CONTROL   = 7'h00;
   localparam logic [6:0] OFS_RATE_GEN_A      = 7'h04;
   localparam logic [6:0] OFS_RATE_GEN_B      = 7'h08;
   localparam logic [6:0] OFS_GROUP_ASSIGN    = 7'h0C;
   localparam logic [6:0] OFS_GROUP_DIVISORS  = 7'h10;
   localparam logic [6:0] OFS_RESERVED_14     = 7'h14;
   localparam logic [6:0] OFS_SYNTH_REF_FREQ  = 7'h18;
   localparam logic [6:0] OFS_TIMING_REF_SYNC = 7'h1C;
   localparam logic [6:0] OFS_BUFFER_CONTROL  = 7'h20;
   localparam logic [6:0] OFS_BOARD_OPTIONS   = 7'h24;
   localparam logic [6:0] OFS_FILL_COUNT      = 7'h28;
   localparam logic [6:0] OFS_CAL_VALUES      = 7'h2C;
   localparam logic [6:0] OFS_DATA_FIFO       = 7'h30;

   // Reset values
   localparam logic [31:0] RST_BOARD_CONTROL    = 32'h0000383C;
   localparam logic [31:0] RST_BOARD_CONTROL_LP = 32'h00003838;
   localparam logic [31:0] RST_RATE_GEN         = 32'h00400032;
   localparam logic [31:0] RST_GROUP_ASSIGN     = 32'h00000000;
   localparam logic [31:0] RST_GROUP_DIVISORS   = 32'h00000505;
   localparam logic [31:0] RST_TIMING_REF_SYNC  = 32'h00002000;
   localparam logic [31:0] RST_BUFFER_CONTROL   = 32'h0003FFFE;

   // Writable bit masks; everything else is reserved or read-only
   localparam logic [31:0] WMASK_BOARD_CONTROL  = 32'h001F8FFF;
   localparam logic [31:0] WMASK_BUFFER_CONTROL = 32'h000FFFFF;
   localparam logic [31:0] WMASK_FULL           = 32'hFFFFFFFF;

   // Board control bit positions
   localparam int unsigned BC_INITIATOR    = 5;
   localparam int unsigned BC_SW_SYNC      = 6;
   localparam int unsigned BC_AUTOCAL      = 7;
   localparam int unsigned BC_CAL_PASS     = 12;
   localparam int unsigned BC_CHAN_READY   = 13;
   localparam int unsigned BC_THRESH_FLAG  = 14;
   localparam int unsigned BC_INITIALIZE   = 15;
   localparam int unsigned BC_CLR_ON_SYNC  = 17;

   // Buffer control bit positions
   localparam int unsigned BF_THRESH_MSB   = 17;
   localparam int unsigned BF_DISABLE      = 18;
   localparam int unsigned BF_CLEAR        = 19;
   localparam int unsigned BF_FULL         = 24;

   typedef struct packed {
      logic        sel;
      logic        wr;
      logic [6:0]  addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } bus_req_s;

   typedef struct packed {
      logic        ack;
      logic [31:0] rdata;
   } bus_rsp_s;
endpackage : adc_regs_pkg

/* src/adc_board_regs.sv */
// Local register bank of the delta-sigma analog input board
//
// What this block does
// - A target starts its local sync sequence on each incoming sync unless clear-on-sync is set.
// - A target may clear its input buffer on incoming sync when so set.
// - Window decodes from low address bits, so any 32-longword base works.
// - Only full 32-bit accesses act; narrower accesses are acked, no effect.
// - Reserved bits are dropped on write and read back as zero.
// - Offsets 0x00 to 0x30 hold registers except reserved 0x14; 0x34 to 0x7C are reserved.
// - Board control resets to one value, another in low-power build.
// - Board control readback sets its threshold flag when buffer fills.
// - Buffer control resets to default and shows full flag once full.
// - Fill count register reports values held in the input buffer.
// - Data register read pops next value with tag; read-only.
// - Board control combines control bits and status flags in 32 bits.
// - Rate divisors register resets to its default.
// - Group rate assignment register is read-write, resets to zero.
// - Timing reference sync register is read-write with its default.
// - Reference frequency register reads the measured synth frequency.
// - Options register reports firmware revision and fitted options.
// - Software sync on an initiator also pulses the external sync out.
// - With clear-on-sync set, software sync clears the buffer instead.
`timescale 1ns/1ns
`default_nettype none

module adc_board_regs #(
   parameter bit          LOW_POWER   = 1'b0,
   // Arbitrary neutral value
   parameter logic [31:0] OPTIONS_VAL = 32'h00001000
) (
   input  wire logic                     sys_clk,
   input  wire logic                     sys_rst,
   input  wire logic                     clk_en,
   input  wire adc_regs_pkg::bus_req_s   bus_req,
   output adc_regs_pkg::bus_rsp_s        bus_rsp,
   input  wire logic                     adc_valid,
   input  wire logic [31:0]              adc_data,
   output logic                          adc_ready,
   input  wire logic                     sync_in,
   output logic                          sync_out,
   output logic                          adc_sync_pulse,
   output logic                          autocal_start,
   input  wire logic                     chan_ready,
   input  wire logic [31:0]              synth_ref_freq,
   input  wire logic [31:0]              cal_values,
   output logic [31:0]                   board_control_out,
   output logic [31:0]                   rate_gen_a_out,
   output logic [31:0]                   rate_gen_b_out,
   output logic [31:0]                   group_assign_out,
   output logic [31:0]                   group_divisors_out,
   output logic [31:0]                   timing_sync_out
);

   localparam logic [31:0] BC_RST = LOW_POWER ?
      adc_regs_pkg::RST_BOARD_CONTROL_LP : adc_regs_pkg::RST_BOARD_CONTROL;

   typedef struct packed {
      logic [31:0]                  board_control_r;
      logic [31:0]                  rate_gen_a_r;
      logic [31:0]                  rate_gen_b_r;
      logic [31:0]                  group_assign_r;
      logic [31:0]                  group_divisors_r;
      logic [31:0]                  timing_sync_r;
      logic [31:0]                  buffer_control_r;
      logic [15:0][31:0]            fifo_mem_r;
      logic [3:0]                   wr_ptr_r;
      logic [3:0]                   rd_ptr_r;
      logic [4:0]                   fill_r;
      logic [1:0][31:0]             skid_r;
      logic [1:0]                   skid_cnt_r;
      logic                         ack_r;
      logic [31:0]                  rdata_r;
      logic                         sync_out_r;
      logic                         adc_sync_r;
      logic                         autocal_r;
   } state_s;

   state_s st_r;
   state_s st_nxt;

   logic        full_acc;
   logic        do_wr;
   logic        do_rd;
   logic        sw_sync;
   logic        ext_sync;
   logic        clr_mode;
   logic        flush;
   logic        push;
   logic        pop;
   logic        skid_in;
   logic        fifo_full;
   logic [31:0] bc_view;
   logic [31:0] bf_view;
   logic [31:0] rd_val;
   logic [31:0] wd;

   assign fifo_full = (st_r.fill_r == adc_regs_pkg::FIFO_FULL_CNT);
   assign adc_ready = (st_r.skid_cnt_r != 2'h2);

   // Status bits are composed at read time and never stored
   always_comb begin
      bc_view = st_r.board_control_r;
      bc_view[adc_regs_pkg::BC_CAL_PASS] = 1'b1;
      bc_view[adc_regs_pkg::BC_CHAN_READY] = chan_ready;
      // Threshold flag also rises when the buffer is full
      bc_view[adc_regs_pkg::BC_THRESH_FLAG] = fifo_full ||
         ({13'h0000, st_r.fill_r} >
          st_r.buffer_control_r[adc_regs_pkg::BF_THRESH_MSB:0]);
      bf_view = st_r.buffer_control_r;
      bf_view[adc_regs_pkg::BF_FULL] = fifo_full;
   end

   always_comb begin
      wd       = bus_req.wdata;
      full_acc = bus_req.sel && (bus_req.be == 4'hF);
      do_wr    = full_acc && bus_req.wr;
      do_rd    = full_acc && !bus_req.wr;
      st_nxt   = st_r;
      st_nxt.ack_r      = bus_req.sel;
      st_nxt.sync_out_r = 1'b0;
      st_nxt.adc_sync_r = 1'b0;
      st_nxt.autocal_r  = 1'b0;
      // Command bits clear themselves one cycle after being set
      st_nxt.board_control_r[adc_regs_pkg::BC_SW_SYNC]    = 1'b0;
      st_nxt.board_control_r[adc_regs_pkg::BC_AUTOCAL]    = 1'b0;
      st_nxt.board_control_r[adc_regs_pkg::BC_INITIALIZE] = 1'b0;
      st_nxt.buffer_control_r[adc_regs_pkg::BF_CLEAR]     = 1'b0;
      flush    = 1'b0;
      sw_sync  = 1'b0;

      // Decode uses only the low address bits
      if (do_wr) begin
         case (bus_req.addr)
            adc_regs_pkg::OFS_BOARD_CONTROL: begin
               st_nxt.board_control_r =
                  wd & adc_regs_pkg::WMASK_BOARD_CONTROL;
               sw_sync = wd[adc_regs_pkg::BC_SW_SYNC];
               st_nxt.autocal_r = wd[adc_regs_pkg::BC_AUTOCAL];
            end
            adc_regs_pkg::OFS_RATE_GEN_A: st_nxt.rate_gen_a_r = wd;
            adc_regs_pkg::OFS_RATE_GEN_B: st_nxt.rate_gen_b_r = wd;
            adc_regs_pkg::OFS_GROUP_ASSIGN: begin
               st_nxt.group_assign_r = wd;
            end
            adc_regs_pkg::OFS_GROUP_DIVISORS: begin
               st_nxt.group_divisors_r = wd;
            end
            adc_regs_pkg::OFS_TIMING_REF_SYNC: begin
               st_nxt.timing_sync_r = wd;
            end
            adc_regs_pkg::OFS_BUFFER_CONTROL: begin
               st_nxt.buffer_control_r =
                  wd & adc_regs_pkg::WMASK_BUFFER_CONTROL;
               flush = wd[adc_regs_pkg::BF_CLEAR];
            end
            // Read-only and reserved offsets swallow the write
            default: ;
         endcase
      end

      // Clear-on-sync mode taken from the value being written, if any
      clr_mode = (do_wr && bus_req.addr == adc_regs_pkg::OFS_BOARD_CONTROL) ?
         wd[adc_regs_pkg::BC_CLR_ON_SYNC] :
         st_r.board_control_r[adc_regs_pkg::BC_CLR_ON_SYNC];
      ext_sync = sync_in && !st_r.board_control_r[adc_regs_pkg::BC_INITIATOR];

      if (sw_sync || ext_sync) begin
         if (clr_mode) begin
            flush = 1'b1;
         end else begin
            st_nxt.adc_sync_r = 1'b1;
         end
      end
      // A target repeats its input downstream; an initiator drives its own
      if (ext_sync) begin
         st_nxt.sync_out_r = 1'b1;
      end
      if (sw_sync && !clr_mode &&
          st_r.board_control_r[adc_regs_pkg::BC_INITIATOR]) begin
         st_nxt.sync_out_r = 1'b1;
      end

      // Initialize returns the bank to defaults and empties the buffer
      if (do_wr && bus_req.addr == adc_regs_pkg::OFS_BOARD_CONTROL &&
          wd[adc_regs_pkg::BC_INITIALIZE]) begin
         st_nxt.board_control_r  = BC_RST & adc_regs_pkg::WMASK_BOARD_CONTROL;
         st_nxt.rate_gen_a_r     = adc_regs_pkg::RST_RATE_GEN;
         st_nxt.rate_gen_b_r     = adc_regs_pkg::RST_RATE_GEN;
         st_nxt.group_assign_r   = adc_regs_pkg::RST_GROUP_ASSIGN;
         st_nxt.group_divisors_r = adc_regs_pkg::RST_GROUP_DIVISORS;
         st_nxt.timing_sync_r    = adc_regs_pkg::RST_TIMING_REF_SYNC;
         st_nxt.buffer_control_r = adc_regs_pkg::RST_BUFFER_CONTROL;
         st_nxt.adc_sync_r       = 1'b0;
         st_nxt.sync_out_r       = 1'b0;
         flush = 1'b1;
      end

      // Read mux; a data read on an empty buffer returns zero
      pop = 1'b0;
      case (bus_req.addr)
         adc_regs_pkg::OFS_BOARD_CONTROL:   rd_val = bc_view;
         adc_regs_pkg::OFS_RATE_GEN_A:      rd_val = st_r.rate_gen_a_r;
         adc_regs_pkg::OFS_RATE_GEN_B:      rd_val = st_r.rate_gen_b_r;
         adc_regs_pkg::OFS_GROUP_ASSIGN:    rd_val = st_r.group_assign_r;
         adc_regs_pkg::OFS_GROUP_DIVISORS:  rd_val = st_r.group_divisors_r;
         adc_regs_pkg::OFS_SYNTH_REF_FREQ:  rd_val = synth_ref_freq;
         adc_regs_pkg::OFS_TIMING_REF_SYNC: rd_val = st_r.timing_sync_r;
         adc_regs_pkg::OFS_BUFFER_CONTROL:  rd_val = bf_view;
         adc_regs_pkg::OFS_BOARD_OPTIONS:   rd_val = OPTIONS_VAL;
         adc_regs_pkg::OFS_FILL_COUNT: begin
            rd_val = {27'h0000000, st_r.fill_r};
         end
         adc_regs_pkg::OFS_CAL_VALUES:      rd_val = cal_values;
         adc_regs_pkg::OFS_DATA_FIFO: begin
            pop = do_rd && (st_r.fill_r != 5'h00);
            rd_val = pop ? st_r.fifo_mem_r[st_r.rd_ptr_r] : 32'h00000000;
         end
         default: rd_val = 32'h00000000;
      endcase
      st_nxt.rdata_r = do_rd ? rd_val : 32'h00000000;

      // Two-entry skid stage ahead of the buffer so a stall loses no word
      skid_in = adc_valid && adc_ready;
      push = (st_r.skid_cnt_r != 2'h0) && !fifo_full && !flush &&
             !st_r.buffer_control_r[adc_regs_pkg::BF_DISABLE];
      if (push) begin
         st_nxt.fifo_mem_r[st_r.wr_ptr_r] = st_r.skid_r[0];
         st_nxt.wr_ptr_r = st_r.wr_ptr_r + 4'h1;
         st_nxt.skid_r[0] = st_r.skid_r[1];
      end
      case ({skid_in, push})
         2'b10: begin
            st_nxt.skid_r[st_r.skid_cnt_r[0]] = adc_data;
            st_nxt.skid_cnt_r = st_r.skid_cnt_r + 2'h1;
         end
         2'b01: st_nxt.skid_cnt_r = st_r.skid_cnt_r - 2'h1;
         2'b11: begin
            st_nxt.skid_r[st_r.skid_cnt_r[0] ^ 1'b1] = adc_data;
         end
         default: ;
      endcase

      if (pop) begin
         st_nxt.rd_ptr_r = st_r.rd_ptr_r + 4'h1;
      end
      // A flush drops buffered words but the skid stage keeps its contents
      if (flush) begin
         st_nxt.wr_ptr_r = 4'h0;
         st_nxt.rd_ptr_r = 4'h0;
         st_nxt.fill_r   = 5'h00;
      end else begin
         case ({push, pop})
            2'b10:   st_nxt.fill_r = st_r.fill_r + 5'h01;
            2'b01:   st_nxt.fill_r = st_r.fill_r - 5'h01;
            default: st_nxt.fill_r = st_r.fill_r;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= '0;
         st_r.board_control_r  <= BC_RST &
                                  adc_regs_pkg::WMASK_BOARD_CONTROL;
         st_r.rate_gen_a_r     <= adc_regs_pkg::RST_RATE_GEN;
         st_r.rate_gen_b_r     <= adc_regs_pkg::RST_RATE_GEN;
         st_r.group_assign_r   <= adc_regs_pkg::RST_GROUP_ASSIGN;
         st_r.group_divisors_r <= adc_regs_pkg::RST_GROUP_DIVISORS;
         st_r.timing_sync_r    <= adc_regs_pkg::RST_TIMING_REF_SYNC;
         st_r.buffer_control_r <= adc_regs_pkg::RST_BUFFER_CONTROL;
      end else if (clk_en) begin
         st_r <= st_nxt;
      end
   end

   assign bus_rsp.ack         = st_r.ack_r;
   assign bus_rsp.rdata       = st_r.rdata_r;
   assign sync_out            = st_r.sync_out_r;
   assign adc_sync_pulse      = st_r.adc_sync_r;
   assign autocal_start       = st_r.autocal_r;
   assign board_control_out   = st_r.board_control_r;
   assign rate_gen_a_out      = st_r.rate_gen_a_r;
   assign rate_gen_b_out      = st_r.rate_gen_b_r;
   assign group_assign_out    = st_r.group_assign_r;
   assign group_divisors_out  = st_r.group_divisors_r;
   assign timing_sync_out     = st_r.timing_sync_r;

endmodule : adc_board_regs

`default_nettype wire

/* dv/adc_board_regs_props.sv */
// Port-level assertions for the board register bank
`timescale 1ns/1ns
`default_nettype none
module adc_board_regs_props (
   input wire logic                   sys_clk,
   input wire logic                   sys_rst,
   input wire logic                   clk_en,
   input wire adc_regs_pkg::bus_req_s bus_req,
   input wire adc_regs_pkg::bus_rsp_s bus_rsp,
   input wire logic                   sync_in,
   input wire logic                   sync_out,
   input wire logic                   adc_sync_pulse,
   input wire logic [31:0]            board_control_out
);
   logic take;
   logic full_rd;
   logic bc_wr;
   logic sw;
   assign take = clk_en && bus_req.sel;
   assign full_rd = take && !bus_req.wr && bus_req.be == 4'hF;
   assign bc_wr = take && bus_req.wr && bus_req.be == 4'hF
                  && bus_req.addr == 7'h00;
   // Initialize wins over a software sync written in the same word
   assign sw = bc_wr && bus_req.wdata[6] && !bus_req.wdata[15];
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   // A control write in the same cycle may change mode or muddle the pulse
   sequence s_ext;
      clk_en && sync_in && !board_control_out[5] && !bc_wr;
   endsequence
   sequence s_sw(logic clr);
      sw && bus_req.wdata[17] == clr;
   endsequence
   a_ack_next: assert property (take |=> bus_rsp.ack)
      else $error("ack missing after request");
   a_ack_idle: assert property (clk_en && !bus_req.sel |=> !bus_rsp.ack)
      else $error("ack without request");
   a_narrow_zero: assert property (take && bus_req.be != 4'hF
      |=> bus_rsp.rdata == 32'h0) else $error("narrow access gave data");
   a_rsvd_read_zero: assert property (full_rd && (bus_req.addr >= 7'h34
      || bus_req.addr == 7'h14) |=> bus_rsp.rdata == 32'h0)
      else $error("reserved offset read not zero");
   a_bc_rsvd_bits: assert property ((board_control_out
      & ~adc_regs_pkg::WMASK_BOARD_CONTROL) == 32'h0)
      else $error("reserved control bits stored");
   a_buf_rsvd_bits: assert property (full_rd && bus_req.addr == 7'h20
      |=> bus_rsp.rdata[31:25] == 7'h0 && bus_rsp.rdata[23:20] == 4'h0)
      else $error("reserved buffer bits read high");
   a_ext_sync_out: assert property (s_ext |=> sync_out)
      else $error("target sync not passed on");
   a_ext_sync_local: assert property (s_ext ##0 !board_control_out[17]
      |=> adc_sync_pulse) else $error("target sync not started");
   a_ext_sync_clear: assert property (s_ext ##0 board_control_out[17]
      |=> !adc_sync_pulse) else $error("sync while clearing");
   a_sw_sync_init: assert property (s_sw(1'b0) ##0 board_control_out[5]
      |=> adc_sync_pulse && sync_out) else $error("software sync missing");
   a_sw_clear_only: assert property (s_sw(1'b1) ##0 !sync_in
      |=> !adc_sync_pulse && !sync_out) else $error("sync on buffer clear");
endmodule : adc_board_regs_props
bind adc_board_regs adc_board_regs_props u_props (.sys_clk(sys_clk),
   .sys_rst(sys_rst), .clk_en(clk_en), .bus_req(bus_req),
   .bus_rsp(bus_rsp), .sync_in(sync_in), .sync_out(sync_out),
   .adc_sync_pulse(adc_sync_pulse), .board_control_out(board_control_out));
`default_nettype wire

/* dv/sample_source.sv */
// Converter-side sample source feeding the input stream
`timescale 1ns/1ns
`default_nettype none
module sample_source #(
   parameter logic [31:0] BASE = 32'hA5000000
) (
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic        go,
   input  wire logic        slow,
   output logic             adc_valid,
   output logic [31:0]      adc_data,
   input  wire logic        adc_ready
);
   logic [31:0] sent;
   logic        took;
   logic        start;
   always @(posedge sys_clk or posedge sys_rst) begin
      took <= sys_rst ? 1'b0 : (adc_valid && adc_ready);
   end
   // Slow mode idles a cycle after each word; idle data keeps toggling
   assign start = go && !(slow && took);
   always @(negedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         adc_valid <= 1'b0;
         adc_data  <= 32'h0;
         sent      <= BASE;
      end else if (!(adc_valid && !took)) begin
         sent      <= sent + {31'h0, took};
         adc_valid <= start;
         adc_data  <= start ? sent + {31'h0, took} : ~adc_data;
      end
   end
endmodule : sample_source
`default_nettype wire

/* dv/adc_board_regs_tb.sv */
// Self-checking bench for the board register bank
`timescale 1ns/1ns
`default_nettype none
module adc_board_regs_tb;
   localparam logic [31:0] OPTS = 32'h00001000; // Arbitrary value
   localparam logic [31:0] FREQ = 32'h1234ABCD;
   localparam logic [31:0] CAL  = 32'h0BADF00D;
   localparam logic [31:0] BASE = 32'hA5000000;
   logic                   sys_clk, sys_rst, adc_valid, adc_ready;
   logic                   sync_in, sync_out, adc_sync_pulse;
   logic                   chan_ready, go, slow, got_sync, got_out;
   logic                   autocal, got_cal;
   logic [31:0]            bc_out, ra_out, rb_out, ga_out, gd_out, ts_out;
   logic [31:0]            adc_data, rd_data;
   adc_regs_pkg::bus_req_s bus_req;
   adc_regs_pkg::bus_rsp_s bus_rsp;
   int                     fails, cmp_count, i;
   logic [6:0]  ofs [6] = '{7'h04, 7'h08, 7'h0C, 7'h10, 7'h1C, 7'h20};
   logic [31:0] dflt [6] = '{32'h00400032, 32'h00400032, 32'h0,
                             32'h00000505, 32'h00002000, 32'h0003FFFE};
   logic [6:0]  ro_ofs [6] = '{7'h14, 7'h18, 7'h24, 7'h2C, 7'h34, 7'h7C};
   logic [31:0] ro_val [6] = '{32'h0, FREQ, OPTS, CAL, 32'h0, 32'h0};
   adc_board_regs #(.LOW_POWER(1'b0), .OPTIONS_VAL(OPTS)) dut (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(1'b1),
      .bus_req(bus_req), .bus_rsp(bus_rsp), .adc_valid(adc_valid),
      .adc_data(adc_data), .adc_ready(adc_ready), .sync_in(sync_in),
      .sync_out(sync_out), .adc_sync_pulse(adc_sync_pulse),
      .autocal_start(autocal), .chan_ready(chan_ready),
      .synth_ref_freq(FREQ), .cal_values(CAL), .board_control_out(bc_out),
      .rate_gen_a_out(ra_out), .rate_gen_b_out(rb_out),
      .group_assign_out(ga_out), .group_divisors_out(gd_out),
      .timing_sync_out(ts_out));
   sample_source #(.BASE(BASE)) src (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .go(go), .slow(slow), .adc_valid(adc_valid), .adc_data(adc_data),
      .adc_ready(adc_ready));
   task automatic report_and_stop;
      if (fails == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : report_and_stop
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // One access per call; an idle cycle follows so sel never falls and
   // rises in one time step between back-to-back calls
   task automatic bus(input logic wr, input logic [6:0] a,
                      input logic [3:0] be, input logic [31:0] wd);
      int n;
      bus_req = '{1'b1, wr, a, be, wd};
      @(negedge sys_clk);
      bus_req.sel = 1'b0;
      n = 0;
      while (bus_rsp.ack !== 1'b1 && n < 8) begin
         @(negedge sys_clk);
         n++;
      end
      if (n == 8) begin
         check(32'h0, 32'h1);
         report_and_stop();
      end
      rd_data = bus_rsp.rdata;
      got_sync = adc_sync_pulse;
      got_out = sync_out;
      got_cal = autocal;
      @(negedge sys_clk);
   endtask : bus
   task automatic rd(input logic [6:0] a, input logic [31:0] exp);
      bus(1'b0, a, 4'hF, 32'h0);
      check(rd_data, exp);
   endtask : rd
   task automatic wr(input logic [6:0] a, input logic [31:0] d);
      bus(1'b1, a, 4'hF, d);
   endtask : wr
   task automatic wait_fill(input logic [31:0] n);
      int k;
      k = 0;
      rd_data = 32'hFFFFFFFF;
      while (rd_data !== n && k < 200) begin
         bus(1'b0, 7'h28, 4'hF, 32'h0);
         k++;
      end
      check(rd_data, n);
      if (k == 200) report_and_stop();
   endtask : wait_fill
   task automatic feed(input int n);
      go = 1'b1;
      repeat (n) @(negedge sys_clk);
      go = 1'b0;
      repeat (8) @(negedge sys_clk);
   endtask : feed
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   initial begin
      sys_rst = 1'b1;
      bus_req = '0;
      {sync_in, go, slow, fails, cmp_count} = '0;
      chan_ready = 1'b1;
      repeat (10) @(posedge sys_clk);
      @(negedge sys_clk);
      sys_rst = 1'b0;
      rd(7'h00, 32'h0000383C);
      for (i = 0; i < 6; i++) rd(ofs[i], dflt[i]);
      for (i = 0; i < 5; i++) begin
         wr(ofs[i], 32'hFFFFFFFF);
         rd(ofs[i], 32'hFFFFFFFF);
      end
      wr(7'h00, 32'h0000B83C);
      for (i = 0; i < 5; i++) rd(ofs[i], dflt[i]);
      check(ra_out, 32'h00400032);
      check(rb_out, 32'h00400032);
      check(ga_out, 32'h00000000);
      check(gd_out, 32'h00000505);
      check(ts_out, 32'h00002000);
      wr(7'h00, 32'hFFE0393C);
      rd(7'h00, 32'h0000393C);
      check(bc_out, 32'h0000093C);
      chan_ready = 1'b0;
      rd(7'h00, 32'h0000193C);
      chan_ready = 1'b1;
      wr(7'h00, 32'h0000383C);
      wr(7'h00, 32'h000038BC);
      check({31'h0, got_cal}, 32'h1);
      wr(7'h20, 32'hFFF00010);
      rd(7'h20, 32'h00000010);
      wr(7'h20, 32'h0003FFFE);
      for (i = 0; i < 6; i++) begin
         wr(ro_ofs[i], 32'hFFFFFFFF);
         rd(ro_ofs[i], ro_val[i]);
      end
      bus(1'b1, 7'h0C, 4'h3, 32'h12345678);
      rd(7'h0C, 32'h0);
      bus(1'b0, 7'h10, 4'h3, 32'h0);
      check(rd_data, 32'h0);
      wr(7'h00, 32'h0000387C);
      check({30'h0, got_sync, got_out}, 32'h3);
      // Full buffer plus two skid words plus the held word
      slow = 1'b1;
      go = 1'b1;
      wait_fill(32'd16);
      repeat (8) @(negedge sys_clk);
      check({31'h0, adc_ready}, 32'h0);
      go = 1'b0;
      rd(7'h00, 32'h0000783C);
      rd(7'h20, 32'h0103FFFE);
      for (i = 0; i < 19; i++) rd(7'h30, BASE + i);
      rd(7'h28, 32'h0);
      rd(7'h30, 32'h0);
      slow = 1'b0;
      feed(5);
      wr(7'h00, 32'h0002387C);
      check({30'h0, got_sync, got_out}, 32'h0);
      rd(7'h28, 32'h0);
      wr(7'h00, 32'h0002381C);
      feed(5);
      sync_in = 1'b1;
      @(negedge sys_clk);
      sync_in = 1'b0;
      check({30'h0, adc_sync_pulse, sync_out}, 32'h1);
      rd(7'h28, 32'h0);
      wr(7'h00, 32'h0000381C);
      sync_in = 1'b1;
      @(negedge sys_clk);
      sync_in = 1'b0;
      check({30'h0, adc_sync_pulse, sync_out}, 32'h3);
      report_and_stop();
   end
endmodule : adc_board_regs_tb
`default_nettype wire
